// >>> core/aspcm_pkg.sv
// Purpose: Shared constants and helpers for the serial audio port.
// Assumes: 200 MHz system clock; register port indexed by word.
// Notes:   Rate and frame helpers are used by the port, which feeds the step to its clock unit.
package aspcm_pkg;

    localparam int unsigned CLK_HZ     = 200_000_000;
    localparam int unsigned SAMPLE_W   = 16;
    localparam int unsigned I2S_HALF   = 16;
    localparam int unsigned I2S_FRAME  = 32;
    localparam int unsigned PCM_DATA   = 16;
    localparam int unsigned RATE_8K    = 8_000;
    localparam int unsigned RATE_16K   = 16_000;
    localparam int unsigned RATE_48K   = 48_000;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map (word index on the register port)
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h1;
    localparam logic [3:0] REG_TX_L    = 4'h2;
    localparam logic [3:0] REG_TX_R    = 4'h3;
    localparam logic [3:0] REG_RX_L    = 4'h4;
    localparam logic [3:0] REG_RX_R    = 4'h5;

    // Control fields
    localparam int unsigned CTRL_EN     = 0;
    localparam int unsigned CTRL_MASTER = 1;
    localparam int unsigned CTRL_PCM    = 2;
    localparam int unsigned CTRL_SYNC2  = 3;
    localparam int unsigned CTRL_RATE   = 4;
    localparam logic [5:0]  CTRL_RST    = 6'h00;

    // Status fields
    localparam int unsigned STAT_RX_L_NEW  = 0;
    localparam int unsigned STAT_RX_R_NEW  = 1;
    localparam int unsigned STAT_TX_L_USED = 2;
    localparam int unsigned STAT_TX_R_USED = 3;
    localparam int unsigned STAT_WA        = 4;

    localparam logic [15:0] SAMPLE_RST = 16'h0000;
    localparam logic [4:0]  CNT_RST    = 5'h00;
    localparam logic [4:0]  CNT_MAX    = 5'h1F;

    typedef enum logic [1:0]
    {
        ASPCM_RATE_8K  = 2'h0,
        ASPCM_RATE_16K = 2'h1,
        ASPCM_RATE_48K = 2'h2
    } aspcm_rate_t;

    // Index of the last bit clock in one frame for the chosen mode (frame length minus one)
    function automatic logic [4:0] frame_len(input logic pcm, input logic sync2);
        logic [5:0] len;
        len = pcm ? 6'(PCM_DATA + 1 + int'(sync2)) : 6'(I2S_FRAME);
        frame_len = len[4:0] - 5'h01;
    endfunction

    // Half bit periods per second; the clock unit accumulates this against CLK_HZ
    function automatic logic [31:0] nco_step(input logic [1:0] rate, input logic pcm,
                                             input logic sync2);
        int unsigned fs;
        int unsigned len;
        case (rate)
            ASPCM_RATE_16K: fs = RATE_16K;
            ASPCM_RATE_48K: fs = RATE_48K;
            default:        fs = RATE_8K;
        endcase
        len      = pcm ? PCM_DATA + 1 + int'(sync2) : I2S_FRAME;
        nco_step = 32'(2 * len * fs);
    endfunction

endpackage

// >>> core/aspcm_link_clk.sv
// Purpose: Bit clock source (master) or bit clock sampler (slave).
// Assumes: Step input is below CLK_HZ; slave clock far slower than i_mclk.
// Notes:   Gives one-cycle pulses on each rising and falling bit clock edge.
`timescale 1ns/1ps

module aspcm_link_clk
    import aspcm_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_enable,
    input  wire logic        i_master,
    input  wire logic [31:0] i_step,
    input  wire logic        i_bclk_pin,
    output logic             o_bclk,
    output logic             o_rise,
    output logic             o_fall
);

    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic        bclk_q;
    logic        sync1_q;
    logic        sync2_q;
    logic        sync3_q;
    logic        rise_q;
    logic        fall_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Fractional accumulator keeps the long-run rate exact even though
    // 200 MHz is not a whole multiple of the bit clock; edges jitter by 5 ns.
    wire [32:0] acc_sum  = {1'b0, acc_q} + {1'b0, i_step};
    wire        nco_wrap = (acc_sum >= 33'(CLK_HZ));
    wire        run_m    = i_enable && i_master;
    wire        tog_m    = run_m && nco_wrap;
    wire        edge_s   = i_enable && !i_master && (sync2_q != sync3_q);

    assign acc_d = nco_wrap ? 32'(acc_sum - 33'(CLK_HZ)) : acc_sum[31:0];

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            acc_q   <= '0;
            bclk_q  <= 1'b0;
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= i_bclk_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            acc_q   <= run_m ? acc_d : '0;
            bclk_q  <= run_m ? (bclk_q ^ nco_wrap) : 1'b0;
            rise_q  <= (tog_m && !bclk_q) || (edge_s && sync2_q);
            fall_q  <= (tog_m && bclk_q) || (edge_s && !sync2_q);
        end
    end

    assign o_bclk = bclk_q;
    assign o_rise = rise_q;
    assign o_fall = fall_q;

endmodule

// >>> core/aspcm_port.sv
// Purpose: Four-wire serial audio port, stereo or pulse-sync framing.
// Assumes: Register port master holds strobes one cycle, never both at once.
// Notes:   Data changes on bit clock falling edges and is sampled on rising.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps

module aspcm_port
    import aspcm_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic             o_pulse_mode_data_out,
    input  wire logic        i_pulse_mode_data_in,
    input  wire logic        i_pulse_mode_clock_i,
    output logic             o_pulse_mode_clock_o,
    output logic             o_pulse_mode_clock_oe,
    input  wire logic        i_audio_word_align_i,
    output logic             o_audio_word_align_o,
    output logic             o_audio_word_align_oe,
    output logic             o_audio_port_zero_pulse_naming
);

    logic [5:0]  ctrl_q;
    logic [15:0] tx_l_q;
    logic [15:0] tx_r_q;
    logic [15:0] sh_l_q;
    logic [15:0] sh_r_q;
    logic [15:0] rx_l_q;
    logic [15:0] rx_r_q;
    logic [15:0] shift_q;
    logic [3:0]  flag_q;
    logic [4:0]  cnt_q;
    logic [4:0]  pos_q;
    logic        wa_q;
    logic        wa_prev_q;
    logic        dout_q;
    logic        wa_oe_q;
    logic        clk_oe_q;
    logic [31:0] rdata_q;
    logic        wa1_q;
    logic        wa2_q;
    logic        din1_q;
    logic        din2_q;
    logic        bclk;
    logic        b_rise;
    logic        b_fall;

    ////////////////////////////////////////////////////////////////////////////////
    // Control decode
    wire        en     = ctrl_q[CTRL_EN];
    wire        master = ctrl_q[CTRL_MASTER];
    wire        pcm    = ctrl_q[CTRL_PCM];
    wire        sync2  = ctrl_q[CTRL_SYNC2];
    wire [1:0]  rate   = ctrl_q[CTRL_RATE +: 2];
    wire [31:0] step   = nco_step(rate, pcm, sync2);
    wire [4:0]  last   = frame_len(pcm, sync2);

    wire wr_ctrl = i_wr && (i_addr == REG_CTRL);
    wire wr_tx_l = i_wr && (i_addr == REG_TX_L);
    wire wr_tx_r = i_wr && (i_addr == REG_TX_R);
    wire rd_rx_l = i_rd && (i_addr == REG_RX_L);
    wire rd_rx_r = i_rd && (i_addr == REG_RX_R);

    aspcm_link_clk u_clk
    (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .i_enable   (en),
        .i_master   (master),
        .i_step     (step),
        .i_bclk_pin (i_pulse_mode_clock_i),
        .o_bclk     (bclk),
        .o_rise     (b_rise),
        .o_fall     (b_fall)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Master alignment generator, advanced on falling bit clock edges
    wire [4:0] pos_n   = ((pos_q == last) || (pos_q == CNT_MAX)) ? CNT_RST : pos_q + 5'h01;
    wire [4:0] hi_len  = pcm ? (sync2 ? 5'h02 : 5'h01) : 5'(I2S_HALF);
    wire       wa_n    = (pos_n < hi_len);

    // Alignment as seen at a rising edge: own register or synchronised pin
    wire       wa_bit  = master ? wa_q : wa2_q;
    wire       wa_chg  = (wa_bit != wa_prev_q);
    wire [4:0] cnt_n   = wa_chg ? CNT_RST : ((cnt_q == CNT_MAX) ? cnt_q : cnt_q + 5'h01);

    ////////////////////////////////////////////////////////////////////////////////
    // Receive: stereo fills left while alignment is high, right while low;
    // pulse mode takes the sixteen bits that follow the sync pulse.
    wire        cap_ok  = (cnt_n < 5'(SAMPLE_W)) && (!pcm || !wa_bit);
    wire        cap_end = cap_ok && (cnt_n == 5'(SAMPLE_W - 1));
    wire [15:0] shift_n = {shift_q[14:0], din2_q};
    wire        cap_l   = cap_end && (pcm || wa_bit);
    wire        cap_r   = cap_end && !pcm && !wa_bit;

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit: decide the next bit from the state seen at the last rising edge.
    // Pulse mode keeps the MSB on the line through the sync so a two-clock
    // pulse needs no lookahead.
    wire [4:0] nxt     = cnt_q + 5'h01;
    wire       i2s_new = !pcm && (cnt_q == 5'(SAMPLE_W - 1));
    wire       load_l  = pcm ? wa_prev_q : (i2s_new && !wa_prev_q);
    wire       load_r  = i2s_new && wa_prev_q;
    wire       use_l   = pcm || wa_prev_q;
    wire [15:0] cur    = use_l ? sh_l_q : sh_r_q;
    wire       in_word = (nxt < 5'(SAMPLE_W));
    wire       bit_n   = load_l ? tx_l_q[SAMPLE_W-1] :
                         load_r ? tx_r_q[SAMPLE_W-1] :
                         in_word ? cur[4'hF - nxt[3:0]] : 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Register port
    wire [31:0] stat_w = {27'h0, wa_bit, flag_q};
    wire [31:0] rd_mux = (i_addr == REG_CTRL)   ? {26'h0, ctrl_q} :
                         (i_addr == REG_STATUS) ? stat_w :
                         (i_addr == REG_TX_L)   ? {16'h0, tx_l_q} :
                         (i_addr == REG_TX_R)   ? {16'h0, tx_r_q} :
                         (i_addr == REG_RX_L)   ? {16'h0, rx_l_q} :
                         (i_addr == REG_RX_R)   ? {16'h0, rx_r_q} : 32'h0;

    // Hardware set wins over the software clear in the same cycle
    wire rise_on = en && b_rise;
    wire fall_on = en && b_fall;
    wire [3:0] f_set = {fall_on && load_r, fall_on && load_l,
                        rise_on && cap_r,  rise_on && cap_l};
    wire [3:0] f_clr = {wr_tx_r, wr_tx_l, rd_rx_r, rd_rx_l};

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            ctrl_q  <= CTRL_RST;
            tx_l_q  <= SAMPLE_RST;
            tx_r_q  <= SAMPLE_RST;
            flag_q  <= '0;
            rdata_q <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= i_wdata[5:0];
            if (wr_tx_l)
                tx_l_q <= i_wdata[15:0];
            if (wr_tx_r)
                tx_r_q <= i_wdata[15:0];
            flag_q  <= f_set | (flag_q & ~f_clr);
            rdata_q <= i_rd ? rd_mux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            wa1_q  <= 1'b0;
            wa2_q  <= 1'b0;
            din1_q <= 1'b0;
            din2_q <= 1'b0;
        end
        else
        begin
            wa1_q  <= i_audio_word_align_i;
            wa2_q  <= wa1_q;
            din1_q <= i_pulse_mode_data_in;
            din2_q <= din1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Framing engine
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst || !en)
        begin
            // Parked on the top count so the first falling edge opens a full slot
            pos_q     <= CNT_MAX;
            wa_q      <= 1'b0;
            cnt_q     <= CNT_RST;
            wa_prev_q <= 1'b0;
            shift_q   <= SAMPLE_RST;
            dout_q    <= 1'b0;
        end
        else
        begin
            if (b_fall && master)
            begin
                pos_q <= pos_n;
                wa_q  <= wa_n;
            end
            if (b_rise)
            begin
                cnt_q     <= cnt_n;
                wa_prev_q <= wa_bit;
                if (cap_ok)
                    shift_q <= shift_n;
            end
            if (b_fall)
                dout_q <= bit_n;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            sh_l_q   <= SAMPLE_RST;
            sh_r_q   <= SAMPLE_RST;
            rx_l_q   <= SAMPLE_RST;
            rx_r_q   <= SAMPLE_RST;
            wa_oe_q  <= 1'b0;
            clk_oe_q <= 1'b0;
        end
        else
        begin
            if (fall_on && load_l)
                sh_l_q <= tx_l_q;
            if (fall_on && load_r)
                sh_r_q <= tx_r_q;
            if (rise_on && cap_l)
                rx_l_q <= shift_n;
            if (rise_on && cap_r)
                rx_r_q <= shift_n;
            // Drive the shared lines only as an enabled master
            wa_oe_q  <= en && master;
            clk_oe_q <= en && master;
        end
    end

    assign o_rdata                        = rdata_q;
    assign o_pulse_mode_data_out          = dout_q;
    assign o_pulse_mode_clock_o           = bclk;
    assign o_pulse_mode_clock_oe          = clk_oe_q;
    assign o_audio_word_align_o           = wa_q;
    assign o_audio_word_align_oe          = wa_oe_q;
    assign o_audio_port_zero_pulse_naming = ctrl_q[CTRL_PCM];

endmodule

// >>> test/aspcm_codec_model.sv
// Purpose: Codec on the far side of the audio port, slave partner and sink.
// Assumes: The bench resolves clock and alignment pins from both enables.
// Notes:   Bit index restarts at each alignment change seen at a rising edge.
`timescale 1ns/1ps
module aspcm_codec_model
(
    input  wire logic        i_run,
    input  wire logic        i_pcm,
    input  wire logic        i_sync2,
    input  wire logic [15:0] i_left,
    input  wire logic [15:0] i_right,
    input  wire logic        i_bclk,
    input  wire logic        i_align,
    input  wire logic        i_dout,
    output logic             o_bclk  = 1'b0,
    output logic             o_align = 1'b0,
    output logic             o_din   = 1'b0,
    output logic      [15:0] o_left  = 16'h0000,
    output logic      [15:0] o_right = 16'h0000
);
    int          cnt = -1;
    int          idx = 0;
    int          nx;
    logic        pa  = 1'b0;
    logic [15:0] sh;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock stands low between runs; a run always finishes its high phase
    always #32
        if (i_run || o_bclk)
        begin
            o_bclk = !o_bclk;
            if (!o_bclk)
            begin
                cnt     = (cnt + 1) % (i_pcm ? 17 + i_sync2 : 32);
                o_align = i_pcm ? cnt < 1 + i_sync2 : cnt < 16;
            end
        end
    always @(posedge i_bclk)
    begin
        idx = (i_align != pa) ? 0 : idx + 1;
        pa  = i_align;
        if ((!i_pcm || !i_align) && idx < 16)
        begin
            sh[15 - idx] = i_dout;
            if (idx == 15 && (i_align || i_pcm))
                o_left = sh;
            else if (idx == 15)
                o_right = sh;
        end
    end
    // Settle time lets a master's alignment land before the next bit is chosen
    always @(negedge i_bclk)
    begin
        #12;
        nx    = (i_align != pa) ? 0 : (i_pcm && i_align) ? 0 : (idx + 1) % 16;
        o_din = (i_align || i_pcm) ? i_left[15 - nx] : i_right[15 - nx];
    end
endmodule

// >>> test/aspcm_port_monitor.sv
// Purpose: Port-level framing checks for the serial audio port.
// Assumes: Sees only top-level ports; bound into every port instance.
// Notes:   Counts bit clock rises per alignment level while driving.
`timescale 1ns/1ps
module aspcm_port_monitor
(
    input  wire logic i_mclk,
    input  wire logic i_sys_rst,
    input  wire logic o_pulse_mode_data_out,
    input  wire logic o_pulse_mode_clock_o,
    input  wire logic o_pulse_mode_clock_oe,
    input  wire logic o_audio_word_align_o,
    input  wire logic o_audio_word_align_oe,
    input  wire logic o_audio_port_zero_pulse_naming
);
    logic       clk_q;
    logic       wa_q;
    logic       arm_q;
    logic [5:0] cnt_q;
    wire        oe   = o_pulse_mode_clock_oe;
    wire        wa   = o_audio_word_align_o;
    wire        pcm  = o_audio_port_zero_pulse_naming;
    wire        chg  = (wa != wa_q) || i_sys_rst;
    wire        rise = o_pulse_mode_clock_o && !clk_q;
    wire  [5:0] cnt_d = chg ? 6'h00 : cnt_q + {5'h00, rise};
    // First level after enable may be partial, so arm only after one change
    always_ff @(posedge i_mclk)
    begin
        clk_q <= o_pulse_mode_clock_o;
        wa_q  <= wa;
        cnt_q <= cnt_d;
        arm_q <= oe && !i_sys_rst && (arm_q || chg);
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_slave_quiet;
        !oe |-> !o_pulse_mode_clock_o;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet)
        else $error("bit clock driven while not enabled master");
    property p_oe_pair;
        o_pulse_mode_clock_oe == o_audio_word_align_oe;
    endproperty
    a_oe_pair: assert property (p_oe_pair)
        else $error("clock and alignment enables differ");
    property p_wa_edge;
        $changed(wa) && oe && $past(oe) |-> !o_pulse_mode_clock_o;
    endproperty
    a_wa_edge: assert property (p_wa_edge)
        else $error("alignment moved while bit clock high");
    property p_data_edge;
        $changed(o_pulse_mode_data_out) && oe && $past(oe) |-> !o_pulse_mode_clock_o;
    endproperty
    a_data_edge: assert property (p_data_edge)
        else $error("data moved while bit clock high");
    property p_i2s_high;
        $fell(wa) && oe && !pcm && arm_q |-> cnt_q == 6'h10;
    endproperty
    a_i2s_high: assert property (p_i2s_high)
        else $error("stereo high phase not sixteen clocks");
    property p_i2s_low;
        $rose(wa) && oe && !pcm && arm_q |-> cnt_q == 6'h10;
    endproperty
    a_i2s_low: assert property (p_i2s_low)
        else $error("stereo low phase not sixteen clocks");
    property p_pcm_sync;
        $fell(wa) && oe && pcm && arm_q |-> cnt_q inside {6'h01, 6'h02};
    endproperty
    a_pcm_sync: assert property (p_pcm_sync)
        else $error("sync pulse not one or two clocks");
    property p_pcm_data;
        $rose(wa) && oe && pcm && arm_q |-> cnt_q == 6'h10;
    endproperty
    a_pcm_data: assert property (p_pcm_data)
        else $error("pulse mode low phase not sixteen clocks");
endmodule
bind aspcm_port aspcm_port_monitor aspcm_port_monitor_i (.*);

// >>> test/testbench.sv
// Purpose: Self-checking bench for the serial audio port, master and slave.
// Assumes: Codec model on the pins; register reads answer one cycle later.
// Notes:   Rates are measured on the alignment line with 10 ns slack.
`timescale 1ns/1ps
module testbench;
    import aspcm_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [3:0]  i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic        dout, din, clk_o, clk_oe, wa_o, wa_oe, naming, m_bclk, m_wa;
    logic        run = 1'b0, pcm = 1'b0, sync2 = 1'b0;
    logic [15:0] left = 16'h0, right = 16'h0, got_l, got_r, tx_l, tx_r;
    logic [5:0]  cfg [5] = '{6'h03, 6'h13, 6'h23, 6'h27, 6'h2F};
    int          fsv [3] = '{8000, 16000, 48000};
    int          failures = 0, checked = 0, seed = 10;
    real         t0, dt;
    wire         bclk  = clk_oe ? clk_o : m_bclk;
    wire         align = wa_oe ? wa_o : m_wa;
    always #2.5 i_mclk = !i_mclk;
    aspcm_port aspcm_port_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_pulse_mode_data_out(dout), .i_pulse_mode_data_in(din),
        .i_pulse_mode_clock_i(bclk), .o_pulse_mode_clock_o(clk_o),
        .o_pulse_mode_clock_oe(clk_oe), .i_audio_word_align_i(align),
        .o_audio_word_align_o(wa_o), .o_audio_word_align_oe(wa_oe),
        .o_audio_port_zero_pulse_naming(naming));
    aspcm_codec_model aspcm_codec_model_i (.i_run(run), .i_pcm(pcm), .i_sync2(sync2),
        .i_left(left), .i_right(right), .i_bclk(bclk), .i_align(align), .i_dout(dout),
        .o_bclk(m_bclk), .o_align(m_wa), .o_din(din), .o_left(got_l), .o_right(got_r));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        i_addr  <= a;
        i_wdata <= v;
        i_wr    <= 1'b1;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1 chk(o_rdata & m, exp, "register read");
    endtask
    task automatic results;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        wr(REG_STATUS, 32'hFFFF);
        wr(4'hF, 32'h1234);
        rc(REG_CTRL, 32'hFFFFFFFF, 32'h0);
        rc(REG_STATUS, 32'hFFFFFFFF, 32'h0);
        rc(4'hF, 32'hFFFFFFFF, 32'h0);
        chk(32'(clk_oe), 32'h0, "enable at rest");
        $display("test reset done");
        for (int k = 0; k < 3; k++)
        begin
            pcm   = (k == 0);
            sync2 = (k == 0);
            left  = 16'($random(seed));
            right = 16'($random(seed));
            tx_l  = 16'($random(seed));
            tx_r  = 16'($random(seed));
            wr(REG_TX_L, {16'h0, tx_l});
            wr(REG_TX_R, {16'h0, tx_r});
            wr(REG_CTRL, (k == 0) ? 32'h0D : (k == 1) ? 32'h01 : 32'h23);
            run = (k < 2);
            repeat (3) @(posedge align);
            run = 1'b0;
            chk(32'(clk_oe), 32'(k == 2), "clock direction");
            chk({16'h0, got_l}, {16'h0, tx_l}, "sent left");
            rc(REG_STATUS, 32'h5, 32'h5);
            rc(REG_RX_L, 32'hFFFF, {16'h0, left});
            rc(REG_STATUS, 32'h1, 32'h0);
            if (!pcm)
                chk({16'h0, got_r}, {16'h0, tx_r}, "sent right");
            if (!pcm)
                rc(REG_RX_R, 32'hFFFF, {16'h0, right});
            wr(REG_CTRL, 32'h0);
            $display("test data %0d done", k);
        end
        for (int k = 0; k < 5; k++)
        begin
            wr(REG_CTRL, 32'(cfg[k]));
            @(posedge align);
            t0 = $realtime;
            if (cfg[k][2])
                @(posedge align);
            else
                @(negedge align);
            dt = $realtime - t0 - (cfg[k][2] ? 1.0e9 : 0.5e9) / fsv[cfg[k][5:4]];
            chk(32'(dt < 10.0 && dt > -10.0), 32'h1, "frame timing");
            chk(32'(naming), 32'(cfg[k][2]), "naming select");
            wr(REG_CTRL, 32'h0);
            $display("test rate %0d done", k);
        end
        results();
    end
    initial
    begin
        #400_000;
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
endmodule
